// >>> hdl/haptic_cfg_pkg.sv
/*
  Constants for the haptic level configuration register bank: register
  offsets, reset values, the serial control port address and the state
  codes of the control-port receiver.
  Assumes a byte-wide register space reached over a two-wire serial port.
*/
package haptic_cfg_pkg;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam int          NUM_REGS            = 6;
  localparam logic [7:0]  OFS_INPUT_FLOOR     = 8'h12;
  localparam logic [7:0]  OFS_INPUT_CEILING   = 8'h13;
  localparam logic [7:0]  OFS_DRIVE_FLOOR     = 8'h14;
  localparam logic [7:0]  OFS_DRIVE_CEILING   = 8'h15;
  localparam logic [7:0]  OFS_FULL_SCALE_REF  = 8'h16;
  localparam logic [7:0]  OFS_OVERDRIVE_LIMIT = 8'h17;
  localparam logic [7:0]  OFS_FIRST           = OFS_INPUT_FLOOR;

  // Index of each register inside the bank
  localparam int          IDX_INPUT_FLOOR     = 0;
  localparam int          IDX_INPUT_CEILING   = 1;
  localparam int          IDX_DRIVE_FLOOR     = 2;
  localparam int          IDX_DRIVE_CEILING   = 3;
  localparam int          IDX_FULL_SCALE_REF  = 4;
  localparam int          IDX_OVERDRIVE_LIMIT = 5;

  // Reset values, in bank order
  localparam logic [7:0]  RST_INPUT_FLOOR     = 8'h19;
  localparam logic [7:0]  RST_INPUT_CEILING   = 8'hff;
  localparam logic [7:0]  RST_DRIVE_FLOOR     = 8'h19;
  localparam logic [7:0]  RST_DRIVE_CEILING   = 8'hff;
  localparam logic [7:0]  RST_FULL_SCALE_REF  = 8'h3e;
  localparam logic [7:0]  RST_OVERDRIVE_LIMIT = 8'h8c;
  localparam logic [7:0]  RST_VALUES [NUM_REGS] = '{RST_INPUT_FLOOR, RST_INPUT_CEILING,
    RST_DRIVE_FLOOR, RST_DRIVE_CEILING, RST_FULL_SCALE_REF, RST_OVERDRIVE_LIMIT};

  // ********************************************************************
  // Serial control port
  // ********************************************************************
  localparam logic [6:0]  DEV_ADDR_DEFAULT    = 7'h2a;  // Arbitrary value
  localparam logic [7:0]  UNMAPPED_READ       = 8'h00;
  localparam logic [3:0]  BITS_PER_BYTE       = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE       = 4'b0000,
    ST_ADDR       = 4'b0001,
    ST_ADDR_ACK   = 4'b0010,
    ST_PTR        = 4'b0011,
    ST_PTR_ACK    = 4'b0100,
    ST_WDATA      = 4'b0101,
    ST_WDATA_ACK  = 4'b0110,
    ST_RDATA      = 4'b0111,
    ST_RACK       = 4'b1000
  } port_state_t;

endpackage

// >>> hdl/haptic_level_config_regs.sv
/*
  Haptic level configuration register bank with its two-wire serial
  control port, the audio-to-haptic level window and the drive limiter.
  Assumes SCL/SDA come from pins (synchronised here), SDA is open drain
  and resolved outside, and the engine inputs share CORE_CLK_I.
*/
// Functional notes
// - Input floor at 0x12, reset 0x19; inputs below floor are ignored.
// - Input floor code scales as code times 1.8 V over 255 peak-to-peak.
// - Input ceiling at 0x13, reset 0xff, full-scale input with same scaling.
// - Drive floor at 0x14, reset 0x19, minimum drive as code over 255.
// - Drive ceiling at 0x15, reset 0xff, maximum drive as code over 255.
// - Full-scale reference at 0x16, reset 0x3e, used in closed loop.
// - Open loop ignores the full-scale reference; overdrive limit replaces it.
// - Closed loop exceeds the reference only during overdrive or braking.
// - Overdrive limit at 0x17, reset 0x8c, bounds automatic overdrive.
// - Open loop uses the overdrive limit as full-scale reference.
`timescale 1ns/100ps
`default_nettype none

module haptic_level_config_regs
  import haptic_cfg_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  // Clock and reset
  input  wire logic       CORE_CLK_I,
  input  wire logic       RST_I,
  // Serial control port pins
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE_O,
  // Audio-to-haptic path
  input  wire logic [7:0] INPUT_LEVEL_I,
  output logic            INPUT_ACTIVE_O,
  output logic [7:0]      AUDIO_DRIVE_O,
  // Drive engine limiter
  input  wire logic       OPEN_LOOP_I,
  input  wire logic       OVERDRIVE_I,
  input  wire logic       BRAKE_I,
  input  wire logic [7:0] DRIVE_REQ_I,
  output logic [7:0]      FULL_SCALE_REF_O,
  output logic [7:0]      DRIVE_LIMITED_O
);

  logic [7:0]  cfg_r [NUM_REGS];
  logic [2:0]  scl_sync_r, sda_sync_r;
  logic        scl_rise, scl_fall, start_det, stop_det;
  port_state_t state_r;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  shift_r, tx_r, ptr_r, rd_byte;
  logic        rw_r, nack_r, wr_stb_r;
  logic [7:0]  wr_addr_r, wr_data_r, drive_cap;
  // Maps a byte offset to its bank contents; offsets below the bank wrap
  // to large indices, so one compare also rejects them
  function automatic logic [7:0] reg_read(input logic [7:0] ofs);
    logic [7:0] idx;
    idx = ofs - OFS_FIRST;
    reg_read = (idx < 8'(NUM_REGS)) ? cfg_r[idx[2:0]] : UNMAPPED_READ;
  endfunction

  // ********************************************************************
  // Serial port: synchronisers, receiver and transmitter
  // ********************************************************************
  // Stage 0 is read only by stage 1; edges are seen between stages 1 and 2
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
    end else begin
      scl_sync_r <= {scl_sync_r[1:0], SCL_I};
      sda_sync_r <= {sda_sync_r[1:0], SDA_I};
    end
  end

  assign scl_rise  = scl_sync_r[1] & ~scl_sync_r[2];
  assign scl_fall  = ~scl_sync_r[1] & scl_sync_r[2];
  assign start_det = scl_sync_r[1] & scl_sync_r[2] & ~sda_sync_r[1] & sda_sync_r[2];
  assign stop_det  = scl_sync_r[1] & scl_sync_r[2] & sda_sync_r[1] & ~sda_sync_r[2];
  assign rd_byte   = reg_read(ptr_r);
  // Data is sampled on SCL rise and SDA is changed on SCL fall, so the
  // two-cycle synchroniser delay stays well inside the SCL low time
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r   <= 8'h00;
      tx_r      <= 8'h00;
      ptr_r     <= 8'h00;
      rw_r      <= 1'b0;
      nack_r    <= 1'b0;
      SDA_OE_O  <= 1'b0;
      wr_stb_r  <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
    end else begin
      wr_stb_r <= 1'b0;
      if (start_det) begin
        state_r   <= ST_ADDR;
        bit_cnt_r <= 4'h0;
        SDA_OE_O  <= 1'b0;
      end else if (stop_det) begin
        state_r  <= ST_IDLE;
        SDA_OE_O <= 1'b0;
      end else if (scl_rise) begin
        case (state_r)
          ST_ADDR, ST_PTR, ST_WDATA: begin
            shift_r   <= {shift_r[6:0], sda_sync_r[1]};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          ST_RDATA: bit_cnt_r <= bit_cnt_r + 4'h1;
          ST_RACK:  nack_r    <= sda_sync_r[1];
          default:  nack_r    <= nack_r;
        endcase
      end else if (scl_fall) begin
        case (state_r)
          ST_ADDR: begin
            if (bit_cnt_r == BITS_PER_BYTE && shift_r[7:1] == DEV_ADDR) begin
              rw_r     <= shift_r[0];
              SDA_OE_O <= 1'b1;
              state_r  <= ST_ADDR_ACK;
            end else if (bit_cnt_r == BITS_PER_BYTE) begin
              state_r <= ST_IDLE;  // Foreign address: silent until next START
            end
          end
          ST_ADDR_ACK: begin
            bit_cnt_r <= 4'h0;
            if (rw_r) begin
              tx_r     <= rd_byte;
              SDA_OE_O <= ~rd_byte[7];
              state_r  <= ST_RDATA;
            end else begin
              SDA_OE_O <= 1'b0;
              state_r  <= ST_PTR;
            end
          end
          ST_PTR: begin
            if (bit_cnt_r == BITS_PER_BYTE) begin
              ptr_r    <= shift_r;
              SDA_OE_O <= 1'b1;
              state_r  <= ST_PTR_ACK;
            end
          end
          ST_WDATA: begin
            if (bit_cnt_r == BITS_PER_BYTE) begin
              wr_stb_r  <= 1'b1;
              wr_addr_r <= ptr_r;
              wr_data_r <= shift_r;
              ptr_r     <= ptr_r + 8'h01;
              SDA_OE_O  <= 1'b1;
              state_r   <= ST_WDATA_ACK;
            end
          end
          ST_PTR_ACK, ST_WDATA_ACK: begin
            bit_cnt_r <= 4'h0;
            SDA_OE_O  <= 1'b0;
            state_r   <= ST_WDATA;
          end
          ST_RDATA: begin
            if (bit_cnt_r == BITS_PER_BYTE) begin
              SDA_OE_O <= 1'b0;
              ptr_r    <= ptr_r + 8'h01;
              state_r  <= ST_RACK;
            end else begin
              tx_r     <= {tx_r[6:0], 1'b0};
              SDA_OE_O <= ~tx_r[6];
            end
          end
          ST_RACK: begin
            // A master NACK ends the burst; an ACK streams the next byte
            if (nack_r) begin
              state_r <= ST_IDLE;
            end else begin
              bit_cnt_r <= 4'h0;
              tx_r      <= rd_byte;
              SDA_OE_O  <= ~rd_byte[7];
              state_r   <= ST_RDATA;
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end
  // Open-drain data pin only ever pulls low
  always_ff @(posedge CORE_CLK_I) begin
    SDA_O <= 1'b0;
  end
  // ********************************************************************
  // Register bank
  // ********************************************************************
  // One flop group per register; unmapped offsets drop the write
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
    always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
        cfg_r[g] <= RST_VALUES[g];
      end else if (wr_stb_r && wr_addr_r == OFS_FIRST + 8'(g)) begin
        cfg_r[g] <= wr_data_r;
      end
    end
  end

  // ********************************************************************
  // Audio-to-haptic window
  // ********************************************************************
  // Input and floor/ceiling codes share one 1.8 V/255 scale, so a plain
  // code compare is exact; no analog conversion is needed here
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      INPUT_ACTIVE_O <= 1'b0;
      AUDIO_DRIVE_O  <= 8'h00;
    end else if (INPUT_LEVEL_I < cfg_r[IDX_INPUT_FLOOR]) begin
      INPUT_ACTIVE_O <= 1'b0;
      AUDIO_DRIVE_O  <= 8'h00;
    end else begin
      INPUT_ACTIVE_O <= 1'b1;
      if (INPUT_LEVEL_I >= cfg_r[IDX_INPUT_CEILING]) begin
        AUDIO_DRIVE_O <= cfg_r[IDX_DRIVE_CEILING];
      end else if (INPUT_LEVEL_I < cfg_r[IDX_DRIVE_FLOOR]) begin
        AUDIO_DRIVE_O <= cfg_r[IDX_DRIVE_FLOOR];
      end else if (INPUT_LEVEL_I > cfg_r[IDX_DRIVE_CEILING]) begin
        AUDIO_DRIVE_O <= cfg_r[IDX_DRIVE_CEILING];
      end else begin
        AUDIO_DRIVE_O <= INPUT_LEVEL_I;
      end
    end
  end
  // ********************************************************************
  // Drive limiter
  // ********************************************************************
  // Closed loop may rise to the overdrive limit only while overdriving or
  // braking; otherwise the full-scale reference caps the request
  assign drive_cap = (OPEN_LOOP_I || OVERDRIVE_I || BRAKE_I)
                   ? cfg_r[IDX_OVERDRIVE_LIMIT]
                   : cfg_r[IDX_FULL_SCALE_REF];
  // Both limiter outputs are registered, one cycle behind their inputs
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      FULL_SCALE_REF_O <= 8'h00;
      DRIVE_LIMITED_O  <= 8'h00;
    end else begin
      FULL_SCALE_REF_O <= OPEN_LOOP_I ? cfg_r[IDX_OVERDRIVE_LIMIT]
                                      : cfg_r[IDX_FULL_SCALE_REF];
      DRIVE_LIMITED_O  <= (DRIVE_REQ_I > drive_cap) ? drive_cap : DRIVE_REQ_I;
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  AST_FLOOR_IGNORED: assert property (
    INPUT_LEVEL_I < cfg_r[IDX_INPUT_FLOOR] |=> !INPUT_ACTIVE_O && AUDIO_DRIVE_O == 8'h00)
    else $error("Input below floor was not ignored");
  AST_ABOVE_FLOOR_ACTIVE: assert property (
    INPUT_LEVEL_I >= cfg_r[IDX_INPUT_FLOOR] |=> INPUT_ACTIVE_O)
    else $error("Input at or above floor not detected");
  AST_CEILING_FULL: assert property (
    INPUT_LEVEL_I >= cfg_r[IDX_INPUT_CEILING] && INPUT_LEVEL_I >= cfg_r[IDX_INPUT_FLOOR]
      |=> AUDIO_DRIVE_O == $past(cfg_r[IDX_DRIVE_CEILING]))
    else $error("Full-scale input did not give ceiling drive");
  AST_DRIVE_MIN: assert property (
    INPUT_ACTIVE_O && cfg_r[IDX_DRIVE_FLOOR] <= cfg_r[IDX_DRIVE_CEILING]
      && $stable(cfg_r[IDX_DRIVE_FLOOR]) && $stable(cfg_r[IDX_DRIVE_CEILING])
      |-> AUDIO_DRIVE_O >= cfg_r[IDX_DRIVE_FLOOR])
    else $error("Audio drive below drive floor");
  AST_DRIVE_MAX: assert property (
    INPUT_ACTIVE_O && cfg_r[IDX_DRIVE_FLOOR] <= cfg_r[IDX_DRIVE_CEILING]
      && $stable(cfg_r[IDX_DRIVE_FLOOR]) && $stable(cfg_r[IDX_DRIVE_CEILING])
      |-> AUDIO_DRIVE_O <= cfg_r[IDX_DRIVE_CEILING])
    else $error("Audio drive above drive ceiling");
  AST_CLOSED_REF: assert property (
    !RST_I && !OPEN_LOOP_I |=> FULL_SCALE_REF_O == $past(cfg_r[IDX_FULL_SCALE_REF]))
    else $error("Closed loop full-scale reference wrong");
  AST_OPEN_REF: assert property (
    OPEN_LOOP_I |=> FULL_SCALE_REF_O == $past(cfg_r[IDX_OVERDRIVE_LIMIT]))
    else $error("Open loop full-scale reference wrong");
  AST_NO_EXCESS: assert property (
    !OPEN_LOOP_I && !OVERDRIVE_I && !BRAKE_I
      |=> DRIVE_LIMITED_O <= $past(cfg_r[IDX_FULL_SCALE_REF]))
    else $error("Drive above reference outside overdrive or braking");
  AST_OVERDRIVE_LIMIT: assert property (
    OVERDRIVE_I |=> DRIVE_LIMITED_O <= $past(cfg_r[IDX_OVERDRIVE_LIMIT]))
    else $error("Overdrive exceeded the limit");
  AST_WRITE_LANDS: assert property (
    wr_stb_r && wr_addr_r == OFS_OVERDRIVE_LIMIT |=> cfg_r[IDX_OVERDRIVE_LIMIT] == $past(wr_data_r))
    else $error("Register write was not stored");
  COV_WRITE: cover property (wr_stb_r);
  COV_BURST: cover property (state_r == ST_RACK && scl_fall && !nack_r);
  COV_READ: cover property (state_r == ST_RDATA && scl_fall);
  COV_IGNORED: cover property (INPUT_LEVEL_I < cfg_r[IDX_INPUT_FLOOR]);
  COV_OVERDRIVE: cover property (OVERDRIVE_I && DRIVE_REQ_I > cfg_r[IDX_OVERDRIVE_LIMIT]);
endmodule
`default_nettype wire

// >>> bench/cfg_port_host.sv
/*
  Host model for the two-wire control port: START, STOP, byte
  transfers and register read/write transactions.
  Assumes a pulled-up data wire resolved by the bench, and a core clock.
*/
`timescale 1ns/100ps
`default_nettype none

module cfg_port_host #(
  parameter int HALF = 8
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // ********
  // Wire-level primitives
  // ********
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Data moves 2 clocks after the clock fall so it is never read as START/STOP
  task automatic bit_xfer(input logic b, output logic s);
    wait_clk(2);
    sda_low_o <= ~b;
    wait_clk(HALF);
    scl_o <= 1'b1;
    wait_clk(HALF / 2);
    s = sda_i;
    wait_clk(HALF / 2);
    scl_o <= 1'b0;
  endtask

  // Eight bits MSB first, then the acknowledge bit
  task automatic byte_xfer(input logic [7:0] d, input logic ack_in,
                           output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], s);
      q[i] = s;
    end
    bit_xfer(ack_in, s);
    ack = ~s;
  endtask

  // Serves as first and repeated START
  task automatic start_cond();
    wait_clk(2);
    sda_low_o <= 1'b0;
    wait_clk(HALF);
    scl_o <= 1'b1;
    wait_clk(HALF);
    sda_low_o <= 1'b1;
    wait_clk(HALF);
    scl_o <= 1'b0;
  endtask

  task automatic stop_cond();
    wait_clk(2);
    sda_low_o <= 1'b1;
    wait_clk(HALF);
    scl_o <= 1'b1;
    wait_clk(HALF);
    sda_low_o <= 1'b0;
    wait_clk(HALF);
  endtask

  // Byte-wide register write: address, pointer, data
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
                           input logic [7:0] val, output logic ok);
    logic [7:0] q;
    logic       a0, a1, a2;
    start_cond();
    byte_xfer({dev, 1'b0}, 1'b1, q, a0);
    byte_xfer(ofs, 1'b1, q, a1);
    byte_xfer(val, 1'b1, q, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask

  // Byte-wide read; without a pointer phase the current pointer is used
  task automatic read_reg(input logic [6:0] dev, input logic set_ptr,
                          input logic [7:0] ofs, output logic [7:0] val,
                          output logic ok);
    logic [7:0] q;
    logic       a0, a1, a2, a3;
    a0 = 1'b1;
    a1 = 1'b1;
    if (set_ptr) begin
      start_cond();
      byte_xfer({dev, 1'b0}, 1'b1, q, a0);
      byte_xfer(ofs, 1'b1, q, a1);
    end
    start_cond();
    byte_xfer({dev, 1'b1}, 1'b1, q, a2);
    byte_xfer(8'hff, 1'b1, val, a3);  // Nack ends the read
    stop_cond();
    ok = a0 & a1 & a2;
  endtask

  // Two-byte burst from the current pointer: ACK the first byte, NACK the last
  task automatic read_two(input logic [6:0] dev, output logic [15:0] val,
                          output logic ok);
    logic [7:0] q;
    logic       a0, a1;
    start_cond();
    byte_xfer({dev, 1'b1}, 1'b1, q, ok);
    byte_xfer(8'hff, 1'b0, val[15:8], a0);  // Master ACK streams the next byte
    byte_xfer(8'hff, 1'b1, val[7:0], a1);
    stop_cond();
  endtask
endmodule

`default_nettype wire

// >>> bench/tb_top.sv
/*
  Self-checking bench for the haptic level register bank.
  Assumes the host model on the control port and a pulled-up data wire.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import haptic_cfg_pkg::*;
  // ********
  // Stimulus, shadow registers and checking
  // ********
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] lvl = 8'h00;
  logic [7:0] req = 8'h00;
  logic       open_l = 1'b0;
  logic       od = 1'b0;
  logic       brk = 1'b0;
  logic       scl, host_low, dev_oe, sda_dev, act;
  logic [7:0] aud, fsr, lim;
  logic [7:0] sh [NUM_REGS];
  int         bad_count = 0;
  int         cmp_count = 0;
  wire        sda_w = ~(host_low | (dev_oe & ~sda_dev));

  always #12.5 clk = ~clk;

  haptic_level_config_regs dut (.CORE_CLK_I(clk), .RST_I(rst), .SCL_I(scl),
    .SDA_I(sda_w), .SDA_O(sda_dev), .SDA_OE_O(dev_oe), .INPUT_LEVEL_I(lvl),
    .INPUT_ACTIVE_O(act), .AUDIO_DRIVE_O(aud), .OPEN_LOOP_I(open_l),
    .OVERDRIVE_I(od), .BRAKE_I(brk), .DRIVE_REQ_I(req),
    .FULL_SCALE_REF_O(fsr), .DRIVE_LIMITED_O(lim));
  cfg_port_host host (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_low_o(host_low));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Unmapped places read as zero and never hold a write
  function automatic logic [7:0] reg_exp(input logic [7:0] a);
    if (a >= OFS_FIRST && a <= OFS_OVERDRIVE_LIMIT) return sh[a - OFS_FIRST];
    return UNMAPPED_READ;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic ok;
    host.write_reg(DEV_ADDR_DEFAULT, a, v, ok);
    chk({7'h00, ok}, 8'h01);
    if (a >= OFS_FIRST && a <= OFS_OVERDRIVE_LIMIT) sh[a - OFS_FIRST] = v;
  endtask

  task automatic rd(input logic [7:0] a, input logic p);
    logic [7:0] v;
    logic       ok;
    host.read_reg(DEV_ADDR_DEFAULT, p, a, v, ok);
    chk({7'h00, ok}, 8'h01);
    chk(v, reg_exp(a));
  endtask

  // Audio window: below floor silent, top of window pinned to drive ceiling
  function automatic logic [7:0] aud_exp(input logic [7:0] l);
    if (l < sh[0]) return 8'h00;
    if (l >= sh[1]) return sh[3];
    if (l < sh[2]) return sh[2];
    return (l > sh[3]) ? sh[3] : l;
  endfunction

  // Cap is the overdrive limit in open loop, overdrive or braking
  function automatic logic [7:0] lim_exp(input logic [7:0] r, input logic [2:0] m);
    logic [7:0] cap;
    cap = (m != 3'b000) ? sh[5] : sh[4];
    return (r < cap) ? r : cap;
  endfunction

  // Mode bits: open loop, overdrive, braking
  task automatic eng(input logic [7:0] l, input logic [7:0] r, input logic [2:0] m);
    @(posedge clk);
    lvl <= l;
    req <= r;
    {open_l, od, brk} <= m;
    @(posedge clk);
    #1;
    chk({7'h00, act}, {7'h00, l >= sh[0]});
    chk(aud, aud_exp(l));
    chk(fsr, m[2] ? sh[5] : sh[4]);
    chk(lim, lim_exp(r, m));
  endtask

  initial begin
    logic       ok;
    logic [7:0] win [6];
    logic [15:0] pair;
    void'($urandom(32'h80e0));
    win = '{8'h40, 8'hc0, 8'h50, 8'ha0, 8'h30, 8'h90};
    for (int i = 0; i < NUM_REGS; i++) sh[i] = RST_VALUES[i];
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    // Reset values, with unmapped neighbours on both sides
    for (logic [7:0] a = 8'h11; a <= 8'h18; a++) rd(a, 1'b1);
    rd(8'h12, 1'b1);
    rd(8'h13, 1'b0);
    // Burst from the auto-incremented pointer, streamed by a master ACK
    host.read_two(DEV_ADDR_DEFAULT, pair, ok);
    chk({7'h00, ok}, 8'h01);
    chk(pair[15:8], reg_exp(8'h14));
    chk(pair[7:0], reg_exp(8'h15));
    // A foreign device address is not acknowledged and changes nothing
    host.write_reg(DEV_ADDR_DEFAULT ^ 7'h01, 8'h12, 8'h00, ok);
    chk({7'h00, ok}, 8'h00);
    rd(8'h12, 1'b1);
    for (int k = 0; k < 8; k++) eng(8'($urandom), 8'($urandom), 3'(k));
    // Fixed window, all six registers written in bank order; level one below even-index values, at odd-index ones
    for (int i = 0; i < NUM_REGS; i++) wr(8'(OFS_FIRST + 8'(i)), win[i]);
    foreach (win[i]) begin
      for (int k = 0; k < 8; k++) eng(win[i] + 8'(i % 2) - 8'h01, win[i], 3'(k));
    end
    eng(8'hff, 8'hff, 3'b000);
    eng(8'h00, 8'h00, 3'b100);
    // Random register contents and random engine traffic
    for (int r = 0; r < 3; r++) begin
      for (logic [7:0] a = 8'h11; a <= 8'h18; a++) wr(a, 8'($urandom));
      if (r == 0) begin
        for (logic [7:0] a = 8'h11; a <= 8'h18; a++) rd(a, 1'b1);
      end
      repeat (30) eng(8'($urandom), 8'($urandom), 3'($urandom));
    end
    final_report();
  end

  // Transactions cost about 380 to 730 clocks each; this is about 2.4 times the run
  initial begin
    repeat (75000) @(posedge clk);
    bad_count++;
    final_report();
  end
endmodule

`default_nettype wire
